// file: include/usp_pkg.sv
// usp_pkg: wiring mode codes, idle pin levels and reset values for the
// serial transceiver port; shared by the port logic and the bench.
package usp_pkg;

  // wiring mode codes as seen on the configuration input
  typedef logic [1:0] usp_mode_t;
  localparam usp_mode_t MODE_DZ_BIDIR  = 2'h0;  // data/zero-state, 3 wires
  localparam usp_mode_t MODE_DZ_UNIDIR = 2'h1;  // data/zero-state, 6 wires
  localparam usp_mode_t MODE_PM_BIDIR  = 2'h2;  // plus/minus, 4 wires
  localparam usp_mode_t MODE_PM_UNIDIR = 2'h3;  // plus/minus, 6 wires
  localparam usp_mode_t MODE_RESET     = MODE_DZ_BIDIR;

  // transmit enable levels (pin is active low)
  localparam logic TXOE_TRANSMIT = 1'h0;
  localparam logic TXOE_RECEIVE  = 1'h1;

  // levels driven on outputs while not transmitting (idle J state)
  localparam logic IDLE_DATA_PLUS  = 1'h1;
  localparam logic IDLE_ZERO_MINUS = 1'h0;

  // reset values of the received line state toward the controller
  localparam logic RX_DIFF_RESET  = 1'h1;
  localparam logic RX_PLUS_RESET  = 1'h1;
  localparam logic RX_MINUS_RESET = 1'h0;
  localparam logic RX_ZERO_RESET  = 1'h0;

endpackage : usp_pkg

// file: rtl/usp_port.sv
// usp_port: pin-level port between the usb controller and an external
// full/low-speed transceiver, in one of four wiring modes.
// assumes the transceiver pins are synchronous to core_clk_i and that the
// bench resolves the two shared pins from the output enables.
`timescale 1ns/100ps
`default_nettype none

// Contract
// R1: the port offers four wiring modes: data/zero 3-wire, data/zero 6-wire, plus/minus 4-wire, plus/minus 6-wire.
// R2: the transmit enable pin is active low, low while sending and high while the transceiver reports the line.
// R3: in data/zero 3-wire mode the data pin carries transmit data while sending and the differential receive value otherwise.
// R4: in data/zero 3-wire mode the zero-state pin requests a single-ended zero while sending and reports one otherwise.
// R5: in data/zero 6-wire mode the data and zero-state pins are outputs only, carrying data and the zero request while sending.
// R6: in data/zero 6-wire mode the transceiver presents the buffered plus and minus levels on two inputs while receiving.
// R7: in data/zero 6-wire mode the transceiver drives the differential receive input while receiving.
// R8: in plus/minus 4-wire mode the data pin carries the plus level both ways and a separate input gives the differential value.
// R9: in plus/minus 4-wire mode the second pin carries the minus level, out while sending and in while receiving.
// R10: in plus/minus 6-wire mode plus and minus go out on two outputs and come back on two inputs with a differential input.
// R11: the mode is held while the port is active, receive pins are ignored while sending and shared pins are not driven while receiving.
module usp_port
(
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  // configuration
  input  wire logic             port_enable_i,
  input  wire usp_pkg::usp_mode_t mode_i,
  // transmit request from the controller
  input  wire logic             tx_request_i,
  input  wire logic             tx_data_i,
  input  wire logic             tx_zero_i,
  input  wire logic             tx_plus_i,
  input  wire logic             tx_minus_i,
  // received line state toward the controller
  output logic                  rx_valid_o,
  output logic                  rx_diff_o,
  output logic                  rx_plus_o,
  output logic                  rx_minus_o,
  output logic                  rx_zero_o,
  output usp_pkg::usp_mode_t    mode_o,
  // transceiver pins
  output logic                  tx_output_enable_n_o,
  input  wire logic             line_data_plus_pin_i,
  output logic                  line_data_plus_pin_o,
  output logic                  line_data_plus_pin_oe_o,
  input  wire logic             zero_state_minus_pin_i,
  output logic                  zero_state_minus_pin_o,
  output logic                  zero_state_minus_pin_oe_o,
  input  wire logic             buffered_plus_in_i,
  input  wire logic             buffered_minus_in_i,
  input  wire logic             differential_receive_in_i
);

  // a single-ended zero is both lines low
  function automatic logic is_zero_state(input logic plus, input logic minus);
    is_zero_state = ~plus & ~minus;
  endfunction : is_zero_state

  usp_pkg::usp_mode_t mode_reg;
  usp_pkg::usp_mode_t mode_next;
  logic               txoe_n_reg;
  logic               txoe_n_next;
  logic               dat_reg;
  logic               dat_next;
  logic               zm_reg;
  logic               zm_next;
  logic               dat_oe_reg;
  logic               zm_oe_reg;
  logic               pins_oe_next;
  logic               rx_valid_reg;
  logic               rx_diff_reg;
  logic               rx_diff_next;
  logic               rx_plus_reg;
  logic               rx_plus_next;
  logic               rx_minus_reg;
  logic               rx_minus_next;
  logic               rx_zero_reg;
  logic               rx_zero_next;

  wire logic is_dz_bidir  = (mode_reg == usp_pkg::MODE_DZ_BIDIR);
  wire logic is_pm_bidir  = (mode_reg == usp_pkg::MODE_PM_BIDIR);
  wire logic is_bidir     = is_dz_bidir | is_pm_bidir;
  wire logic is_dz_mode   = is_dz_bidir | (mode_reg == usp_pkg::MODE_DZ_UNIDIR);
  wire logic sending      = port_enable_i & tx_request_i;
  wire logic receiving    = port_enable_i & (txoe_n_reg == usp_pkg::TXOE_RECEIVE);

  // mode only follows the configuration while the port is idle
  assign mode_next   = port_enable_i ? mode_reg : mode_i;  // [R11] [R1]
  assign txoe_n_next = sending ? usp_pkg::TXOE_TRANSMIT : usp_pkg::TXOE_RECEIVE;  // [R2]

  // transmit values: data/zero modes send data and zero request, plus/minus modes the line levels
  assign dat_next = ~sending ? usp_pkg::IDLE_DATA_PLUS :
                    is_dz_mode ? tx_data_i : tx_plus_i;  // [R3] [R5] [R8] [R10]
  assign zm_next  = ~sending ? usp_pkg::IDLE_ZERO_MINUS :
                    is_dz_mode ? tx_zero_i : tx_minus_i;  // [R4] [R5] [R9] [R10]

  // shared pins are driven only while sending; unidirectional pins whenever enabled
  assign pins_oe_next = port_enable_i & (sending | ~is_bidir);  // [R11] [R5]

  // receive decode per mode; the 3-wire mode has no plus/minus inputs, so derive them
  always_comb
  begin
    rx_diff_next  = rx_diff_reg;
    rx_plus_next  = rx_plus_reg;
    rx_minus_next = rx_minus_reg;
    rx_zero_next  = rx_zero_reg;
    if (receiving)  // [R11]
    begin
      case (mode_reg)
        usp_pkg::MODE_DZ_BIDIR:
        begin
          rx_diff_next  = line_data_plus_pin_i;  // [R3]
          rx_zero_next  = zero_state_minus_pin_i;  // [R4]
          rx_plus_next  = ~zero_state_minus_pin_i & line_data_plus_pin_i;
          rx_minus_next = ~zero_state_minus_pin_i & ~line_data_plus_pin_i;
        end
        usp_pkg::MODE_PM_BIDIR:
        begin
          rx_diff_next  = differential_receive_in_i;  // [R8]
          rx_plus_next  = line_data_plus_pin_i;  // [R8]
          rx_minus_next = zero_state_minus_pin_i;  // [R9]
          rx_zero_next  = is_zero_state(line_data_plus_pin_i, zero_state_minus_pin_i);
        end
        default:
        begin
          rx_diff_next  = differential_receive_in_i;  // [R7] [R10]
          rx_plus_next  = buffered_plus_in_i;  // [R6] [R10]
          rx_minus_next = buffered_minus_in_i;  // [R6] [R10]
          rx_zero_next  = is_zero_state(buffered_plus_in_i, buffered_minus_in_i);
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_reg   <= usp_pkg::MODE_RESET;
      txoe_n_reg <= usp_pkg::TXOE_RECEIVE;
      dat_reg    <= usp_pkg::IDLE_DATA_PLUS;
      zm_reg     <= usp_pkg::IDLE_ZERO_MINUS;
      dat_oe_reg <= 1'h0;
      zm_oe_reg  <= 1'h0;
    end
    else
    begin
      mode_reg   <= mode_next;
      txoe_n_reg <= txoe_n_next;
      dat_reg    <= dat_next;
      zm_reg     <= zm_next;
      dat_oe_reg <= pins_oe_next;
      zm_oe_reg  <= pins_oe_next;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_valid_reg <= 1'h0;
      rx_diff_reg  <= usp_pkg::RX_DIFF_RESET;
      rx_plus_reg  <= usp_pkg::RX_PLUS_RESET;
      rx_minus_reg <= usp_pkg::RX_MINUS_RESET;
      rx_zero_reg  <= usp_pkg::RX_ZERO_RESET;
    end
    else
    begin
      rx_valid_reg <= receiving;
      rx_diff_reg  <= rx_diff_next;
      rx_plus_reg  <= rx_plus_next;
      rx_minus_reg <= rx_minus_next;
      rx_zero_reg  <= rx_zero_next;
    end
  end

  assign mode_o                    = mode_reg;
  assign tx_output_enable_n_o      = txoe_n_reg;
  assign line_data_plus_pin_o      = dat_reg;
  assign line_data_plus_pin_oe_o   = dat_oe_reg;
  assign zero_state_minus_pin_o    = zm_reg;
  assign zero_state_minus_pin_oe_o = zm_oe_reg;
  assign rx_valid_o                = rx_valid_reg;
  assign rx_diff_o                 = rx_diff_reg;
  assign rx_plus_o                 = rx_plus_reg;
  assign rx_minus_o                = rx_minus_reg;
  assign rx_zero_o                 = rx_zero_reg;

  // checks

  txoe_follows_req_a: assert property (  // [R2]
    @(posedge core_clk_i) disable iff (rst_i)
    (port_enable_i && tx_request_i) |=> (tx_output_enable_n_o == 1'h0))
    else $error("transmit enable not low after a send request");

  txoe_idle_high_a: assert property (  // [R2]
    @(posedge core_clk_i) disable iff (rst_i)
    !port_enable_i |=> tx_output_enable_n_o && !line_data_plus_pin_oe_o && !zero_state_minus_pin_oe_o)
    else $error("port drives while disabled");

  shared_no_drive_a: assert property (  // [R11]
    @(posedge core_clk_i) disable iff (rst_i)
    (tx_output_enable_n_o && (is_dz_bidir || is_pm_bidir))
      |-> !line_data_plus_pin_oe_o && !zero_state_minus_pin_oe_o)
    else $error("shared pin driven while receiving");

  mode_held_a: assert property (  // [R11]
    @(posedge core_clk_i) disable iff (rst_i)
    port_enable_i |=> $stable(mode_reg))
    else $error("mode changed while port active");

  dz_tx_value_a: assert property (  // [R3]
    @(posedge core_clk_i) disable iff (rst_i)
    (!tx_output_enable_n_o && is_dz_mode)
      |-> line_data_plus_pin_o == $past(tx_data_i) && zero_state_minus_pin_o == $past(tx_zero_i))
    else $error("data or zero request not on pins while sending");

  pm_tx_value_a: assert property (  // [R8]
    @(posedge core_clk_i) disable iff (rst_i)
    (!tx_output_enable_n_o && !is_dz_mode)
      |-> line_data_plus_pin_o == $past(tx_plus_i) && zero_state_minus_pin_o == $past(tx_minus_i))
    else $error("plus or minus not on pins while sending");

  unidir_drive_a: assert property (  // [R5]
    @(posedge core_clk_i) disable iff (rst_i)
    (port_enable_i && $past(port_enable_i) && !(is_dz_bidir || is_pm_bidir))
      |-> line_data_plus_pin_oe_o && zero_state_minus_pin_oe_o)
    else $error("unidirectional pins not driven");

  dz_rx_capture_a: assert property (  // [R4]
    @(posedge core_clk_i) disable iff (rst_i)
    (port_enable_i && tx_output_enable_n_o && is_dz_bidir)
      |=> rx_valid_o && rx_diff_o == $past(line_data_plus_pin_i)
          && rx_zero_o == $past(zero_state_minus_pin_i))
    else $error("3-wire receive not captured");

  uni_rx_capture_a: assert property (  // [R6]
    @(posedge core_clk_i) disable iff (rst_i)
    (port_enable_i && tx_output_enable_n_o && !(is_dz_bidir || is_pm_bidir))
      |=> rx_plus_o == $past(buffered_plus_in_i) && rx_minus_o == $past(buffered_minus_in_i)
          && rx_diff_o == $past(differential_receive_in_i))
    else $error("6-wire receive not captured");

  rx_ignored_tx_a: assert property (  // [R11]
    @(posedge core_clk_i) disable iff (rst_i)
    !tx_output_enable_n_o |=> !rx_valid_o && $stable(rx_diff_o) && $stable(rx_plus_o))
    else $error("receive pins sampled while sending");

endmodule : usp_port

`default_nettype wire

// file: testbench/usp_xcvr_model.sv
// usp_xcvr_model: behavioural full/low-speed transceiver on the pin side.
// assumes the bench sets the bus line state and tells it the wiring mode.
`timescale 1ns/100ps
`default_nettype none
module usp_xcvr_model
(
  // wiring and bus line state
  input  wire logic [1:0] mode_i,
  input  wire logic       line_plus_i,
  input  wire logic       line_minus_i,
  // device pins
  input  wire logic       txoe_n_i,
  input  wire logic       dp_o_i,
  input  wire logic       dp_oe_i,
  input  wire logic       zm_o_i,
  input  wire logic       zm_oe_i,
  output logic            dp_pin_o,
  output logic            zm_pin_o,
  output logic            bplus_o,
  output logic            bminus_o,
  output logic            diff_o
);
  logic drive;
  logic xz;
  always_comb
  begin
    drive = txoe_n_i & ~mode_i[0];
    xz = mode_i[1] ? line_minus_i : (~line_plus_i & ~line_minus_i);
    // a released pin shows the line state in the receiving bidirectional modes, otherwise the inverse of the port's present output value
    dp_pin_o = dp_oe_i ? dp_o_i : (drive ? line_plus_i : ~dp_o_i);
    zm_pin_o = zm_oe_i ? zm_o_i : (drive ? xz : ~zm_o_i);
    bplus_o = txoe_n_i ? line_plus_i : ~line_plus_i;
    bminus_o = txoe_n_i ? line_minus_i : ~line_minus_i;
    diff_o = (txoe_n_i | mode_i == 2'h2) ? line_plus_i : ~line_plus_i;
  end
endmodule : usp_xcvr_model
`default_nettype wire

// file: testbench/testbench.sv
// testbench: random traffic in all four wiring modes against a transceiver model.
// assumes the port and the model above; no waits on design handshakes.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic               core_clk_i = 1'h0;
  logic               rst_i = 1'h1;
  logic               en, req, d, z, p, m, lp, lm;
  usp_pkg::usp_mode_t mode, mode_o;
  logic               vld, rdf, rpl, rmi, rze, txoe, dpo, dpoe, zmo, zmoe;
  logic               dpi, zmi, bp, bm, df;
  int                 miscompares = 0;
  int                 checked = 0;
  logic [31:0]        seed = 32'h962c;
  always #10 core_clk_i = ~core_clk_i;

  usp_port i_usp_port (.core_clk_i(core_clk_i), .rst_i(rst_i), .port_enable_i(en),
    .mode_i(mode), .tx_request_i(req), .tx_data_i(d), .tx_zero_i(z), .tx_plus_i(p),
    .tx_minus_i(m), .rx_valid_o(vld), .rx_diff_o(rdf), .rx_plus_o(rpl), .rx_minus_o(rmi),
    .rx_zero_o(rze), .mode_o(mode_o), .tx_output_enable_n_o(txoe),
    .line_data_plus_pin_i(dpi), .line_data_plus_pin_o(dpo), .line_data_plus_pin_oe_o(dpoe),
    .zero_state_minus_pin_i(zmi), .zero_state_minus_pin_o(zmo),
    .zero_state_minus_pin_oe_o(zmoe), .buffered_plus_in_i(bp), .buffered_minus_in_i(bm),
    .differential_receive_in_i(df));
  usp_xcvr_model i_usp_xcvr_model (.mode_i(mode_o), .line_plus_i(lp), .line_minus_i(lm),
    .txoe_n_i(txoe), .dp_o_i(dpo), .dp_oe_i(dpoe), .zm_o_i(zmo), .zm_oe_i(zmoe),
    .dp_pin_o(dpi), .zm_pin_o(zmi), .bplus_o(bp), .bminus_o(bm), .diff_o(df));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // expected {diff, plus, minus, zero} for a bus line state
  function automatic logic [3:0] exp_rx(input logic [1:0] md, input logic a, input logic b);
    logic ze;
    ze = ~a & ~b;
    if (md == usp_pkg::MODE_DZ_BIDIR)
      return {a, ~ze & a, ~ze & ~a, ze};
    return {a, a, b, ze};
  endfunction : exp_rx

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  initial
  begin
    logic       pr, ptx, pd, pz, pp, pm, plp, plm;
    logic [3:0] erx;
    {en, req, d, z, p, m, lp, lm} = '0;
    mode = '0;
    erx = 4'hc;
    repeat (2) @(posedge core_clk_i);
    #1 rst_i = 1'h0;
    check(8'({txoe, dpo, dpoe, zmo, zmoe, vld}), 8'h30);
    for (int k = 0; k < 4; k++)
    begin
      // let an edge pass so no input is assigned twice in one time step
      @(posedge core_clk_i);
      #1;
      // a request with the port disabled must be ignored
      en = 1'h0;
      req = 1'h1;
      mode = k[1:0];
      @(posedge core_clk_i);
      #1;
      check(8'({txoe, vld, dpoe, zmoe, mode_o}), 8'({4'h8, k[1:0]}));
      en = 1'h1;
      req = 1'h0;
      {pr, ptx, plp, plm} = {1'h0, 1'h1, lp, lm};
      for (int c = 0; c < 300; c++)
      begin
        @(posedge core_clk_i);
        #1;
        check(8'(mode_o), 8'(k[1:0]));
        if (pr)
          check(8'({txoe, dpo, dpoe, zmo, zmoe}), 8'({1'h0, k[1] ? pp : pd, 1'h1,
                k[1] ? pm : pz, 1'h1}));
        else
          check(8'({txoe, dpo, dpoe, zmo, zmoe}),
                8'({1'h1, 1'h1, k[0], 1'h0, k[0]}));
        if (ptx)
          erx = exp_rx(k[1:0], plp, plm);
        check(8'({vld, rdf, rpl, rmi, rze}),
              8'({ptx, erx}));
        ptx = ~pr;
        seed = xs(seed);
        {req, d, z, p, m, lp, lm} = seed[6:0];
        mode = seed[9:8];
        {pr, pd, pz, pp, pm, plp, plm} = seed[6:0];
      end
      $display("wiring mode %0d done", k);
    end
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
